// [core/dpse_defs.svh]
// offsets, field positions, reset values and counts of the paired-port shadow emulation
`ifndef DPSE_DEFS_SVH
`define DPSE_DEFS_SVH
`define DPSE_IX_ERR      4'h0
`define DPSE_IX_CNT      4'h1
`define DPSE_IX_LBL      4'h2
`define DPSE_IX_LBM      4'h3
`define DPSE_IX_LBH      4'h4
`define DPSE_IX_DEV      4'h5
`define DPSE_IX_STAT     4'h6
`define DPSE_IX_CTL      4'h7
`define DPSE_IX_IRQ_ST   4'h8
`define DPSE_IX_IRQ_MASK 4'h9
`define DPSE_IX_PSTAT    4'ha
`define DPSE_IX_TMO      4'hb
`define DPSE_STAT_RST    8'h7f
`define DPSE_REG_RST     8'hff
`define DPSE_CTL_RST     8'h00
`define DPSE_BSY_BIT     7
`define DPSE_DEV_BIT     4
`define DPSE_SOFT_RESET_BIT_BIT    2
`define DPSE_INTERRUPT_DISABLE_BIT_BIT    1
`define DPSE_CMD_DIAG    8'h90
`define DPSE_DIAG_PASS   8'h01
`define DPSE_D1_FAIL     8'h80
`define DPSE_NONE        8'h00
`define DPSE_TMO_RST     24'h0f4240
`define DPSE_IRQ_RX0     0
`define DPSE_IRQ_RX1     1
`define DPSE_IRQ_DONE    2
`define DPSE_IRQ_TMO     3
`endif

// [core/dpse_pkg.sv]
// types shared by the paired-port shadow emulation
package dpse_pkg;
  typedef struct packed {
    logic [7:0] features;
    logic [7:0] count;
    logic [7:0] lba_lo;
    logic [7:0] lba_mid;
    logic [7:0] lba_hi;
    logic [7:0] device;
    logic [7:0] command;
    logic [7:0] control;
  } dpse_tx_type;
  typedef struct packed {
    logic [7:0] error;
    logic [7:0] count;
    logic [7:0] lba_lo;
    logic [7:0] lba_mid;
    logic [7:0] lba_hi;
    logic [7:0] device;
    logic [7:0] status;
    logic       irq;
  } dpse_rx_type;
  typedef enum logic {MRG_IDLE, MRG_WAIT} dpse_mrg_type;
endpackage

// [core/dpse_top.sv]
// paired-port shadow register emulation with apb register access
//
// The APB register port and the placing of the registers are this design's own decisions.
`include "dpse_defs.svh"
module dpse_top (
  // clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        rst,
  // apb slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [11:0]                 paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // physical-layer presence per port
  input  wire logic [1:0]                  port_phy_ready,
  // frames toward the devices
  output logic      [1:0]                  port_tx_valid,
  output dpse_pkg::dpse_tx_type [1:0]      port_tx_frame,
  input  wire logic [1:0]                  port_tx_ready,
  // frames from the devices
  input  wire logic [1:0]                  port_rx_valid,
  input  wire dpse_pkg::dpse_rx_type [1:0] port_rx_frame,
  // interrupts
  output logic                             host_intrq,
  output logic                             irq
);
  logic [7:0]  sh_ff [2][6];
  logic [7:0]  stat_ff [2];
  logic [7:0]  cmd_ff [2];
  logic [7:0]  ctl_ff [2];
  logic [1:0]  ipend_ff;
  logic [1:0]  pend_ff;
  logic [1:0]  txv_ff;
  dpse_pkg::dpse_tx_type [1:0] txf_ff;

  logic        dev_sel_ff;
  logic        soft_reset_bit_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic [31:0] prdata_ff;

  logic [3:0]  irq_st_ff;
  logic [3:0]  irq_mask_ff;
  logic        irq_ff;
  logic        host_intrq_ff;
  logic [23:0] tmo_lim_ff;
  logic [23:0] cnt_ff;
  logic [1:0]  wait_ff;
  logic [1:0]  tmo_ff;
  dpse_pkg::dpse_mrg_type mrg_ff;

  // true for the six plain shadow bytes below the command byte
  function automatic logic is_plain(input logic [3:0] a);
    return a < `DPSE_IX_STAT;
  endfunction

  // apb decode
  wire        setup_end = psel & penable & ~pready_ff;
  wire        access    = psel & penable & pready_ff;
  wire [3:0]  ix        = paddr[5:2];
  wire        mapped    = (paddr[11:6] == 6'h00) && (paddr[1:0] == 2'h0)
                          && (ix <= `DPSE_IX_TMO);
  wire        wr        = access & pwrite & mapped;
  wire        rd        = access & ~pwrite & mapped;
  wire [7:0]  wb        = pwdata[7:0];
  wire        sel       = dev_sel_ff;
  wire [1:0]  present   = port_phy_ready;
  wire        is_dev    = wr && (ix == `DPSE_IX_DEV);
  wire        is_cmd    = wr && (ix == `DPSE_IX_STAT);
  wire        is_ctl    = wr && (ix == `DPSE_IX_CTL);
  wire        is_oth    = wr && (ix < `DPSE_IX_DEV);
  // adapter-only register write strobes
  wire        wr_ist    = wr && (ix == `DPSE_IX_IRQ_ST);
  wire        wr_msk    = wr && (ix == `DPSE_IX_IRQ_MASK);
  wire        wr_tmo    = wr && (ix == `DPSE_IX_TMO);
  wire        st_rd     = rd && (ix == `DPSE_IX_STAT);
  wire        diag      = is_cmd && (wb == `DPSE_CMD_DIAG);
  wire        soft_reset_bit_set  = is_ctl & wb[`DPSE_SOFT_RESET_BIT_BIT];
  // only a clear that follows a set starts the second frame
  wire        soft_reset_bit_clr  = is_ctl & ~wb[`DPSE_SOFT_RESET_BIT_BIT] & soft_reset_bit_ff;
  // secondary selected with nothing attached: primary answers as non-packet
  wire        emul0     = sel & ~present[1];
  wire        rp        = emul0 ? 1'b0 : sel;
  wire        mrg_done  = (mrg_ff == dpse_pkg::MRG_WAIT) && (wait_ff == 2'h0);
  wire        tmo_hit   = (mrg_ff == dpse_pkg::MRG_WAIT) && (cnt_ff >= tmo_lim_ff)
                          && (wait_ff != 2'h0);
  wire        mrg_start = (present != 2'h0) & (soft_reset_bit_clr | diag);

  // merge per the parallel two-device convention; a silent primary counts as absent, a silent secondary as failed
  wire        p0_ok     = present[0] & ~tmo_ff[0];
  wire        p1_fail   = present[1]
                          & (tmo_ff[1] | (sh_ff[1][0] != `DPSE_DIAG_PASS));
  wire [7:0]  mrg_err   = (p0_ok ? sh_ff[0][0] : `DPSE_NONE)
                          | (p1_fail ? `DPSE_D1_FAIL : `DPSE_NONE);
  wire [7:0]  mrg_stat  = p0_ok ? stat_ff[0] : `DPSE_NONE;

  wire [7:0]  rd_stat   = emul0 ? `DPSE_NONE : stat_ff[rp];
  wire [7:0]  rd_shadow = is_plain(ix) ? sh_ff[rp][ix[2:0]] : rd_stat;
  wire [31:0] rd_word   =
    (ix <= `DPSE_IX_CTL)      ? {24'h000000, rd_shadow} :
    (ix == `DPSE_IX_IRQ_ST)   ? {28'h0000000, irq_st_ff} :
    (ix == `DPSE_IX_IRQ_MASK) ? {28'h0000000, irq_mask_ff} :
    (ix == `DPSE_IX_PSTAT)    ? {24'h000000, tmo_ff, wait_ff, soft_reset_bit_ff, sel, present} :
                                {8'h00, tmo_lim_ff};

  wire [3:0]  irq_ev    = {tmo_hit, mrg_done, port_rx_valid};
  wire [3:0]  irq_clr   = wr_ist ? wb[3:0] : 4'h0;
  wire [3:0]  nxt_irq_st = (irq_st_ff & ~irq_clr) | irq_ev;

  // apb slave: one wait state, read data and error valid with pready
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h00000000;
    end
    else
    begin
      pready_ff  <= setup_end;
      pslverr_ff <= setup_end & ~mapped;
      // read data is latched in the wait state so it stands with pready
      if (setup_end)
        prdata_ff <= (~pwrite && mapped) ? rd_word : 32'h00000000;
    end
  end

  // global control state
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      dev_sel_ff  <= 1'b0;
      soft_reset_bit_ff     <= 1'b0;
      irq_st_ff   <= 4'h0;
      irq_mask_ff <= 4'h0;
      irq_ff      <= 1'b0;
      tmo_lim_ff  <= `DPSE_TMO_RST;
    end
    else
    begin
      if (is_dev)
        dev_sel_ff <= wb[`DPSE_DEV_BIT];
      if (is_ctl)
        soft_reset_bit_ff <= wb[`DPSE_SOFT_RESET_BIT_BIT];
      if (wr_msk)
        irq_mask_ff <= wb[3:0];
      if (wr_tmo)
        tmo_lim_ff <= pwdata[23:0];
      irq_st_ff <= nxt_irq_st;
      irq_ff    <= |(nxt_irq_st & irq_mask_ff);
    end
  end

  // reply wait and merge sequencer
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      mrg_ff  <= dpse_pkg::MRG_IDLE;
      wait_ff <= 2'h0;
      tmo_ff  <= 2'h0;
      cnt_ff  <= 24'h000000;
    end
    else
    begin
      case (mrg_ff)
        dpse_pkg::MRG_IDLE:
        begin
          if (mrg_start)
          begin
            mrg_ff  <= dpse_pkg::MRG_WAIT;
            wait_ff <= present;
            tmo_ff  <= 2'h0;
            cnt_ff  <= 24'h000000;
          end
        end
        dpse_pkg::MRG_WAIT:
        begin
          cnt_ff <= cnt_ff + 24'h000001;
          if (mrg_done)
            mrg_ff <= dpse_pkg::MRG_IDLE;
          // a reply in the timeout cycle still counts as an answer
          else if (tmo_hit)
          begin
            tmo_ff  <= wait_ff & ~port_rx_valid;
            wait_ff <= 2'h0;
          end
          else
            wait_ff <= wait_ff & ~port_rx_valid;
        end
        default:
          mrg_ff <= dpse_pkg::MRG_IDLE;
      endcase
    end
  end

  // one shadow set and one frame sender per port
  generate
    for (genvar g = 0; g < 2; g++)
    begin : gen_port
      wire pick   = (sel == 1'(g));
      wire wr_en  = present[g] & (is_dev | is_ctl | diag
                    | ((is_oth | is_cmd) & pick));
      wire send   = present[g] & (soft_reset_bit_set | soft_reset_bit_clr | diag
                    | (is_cmd & pick));
      wire busy_flag    = send & (is_cmd | soft_reset_bit_set);
      wire iclr   = soft_reset_bit_set | ((is_cmd | st_rd) & pick & ~emul0);
      wire ld_mrg = mrg_done & (g == 0);
      wire load   = pend_ff[g] & (~txv_ff[g] | port_tx_ready[g]);
      // frame image of this port's shadow set
      wire dpse_pkg::dpse_tx_type img = {sh_ff[g][0], sh_ff[g][1], sh_ff[g][2], sh_ff[g][3],
                                         sh_ff[g][4], sh_ff[g][5], cmd_ff[g], ctl_ff[g]};

      always_ff @(posedge core_clk or posedge rst)
      begin
        if (rst)
        begin
          // shadows read 0x7f and 0xff until the first device frame lands
          for (int i = 0; i < 6; i++)
            sh_ff[g][i] <= `DPSE_REG_RST;
          stat_ff[g] <= `DPSE_STAT_RST;
          cmd_ff[g]  <= `DPSE_REG_RST;
          ctl_ff[g]  <= `DPSE_CTL_RST;
        end
        else
        begin
          if (port_rx_valid[g])
          begin
            sh_ff[g][0] <= port_rx_frame[g].error;
            sh_ff[g][1] <= port_rx_frame[g].count;
            sh_ff[g][2] <= port_rx_frame[g].lba_lo;
            sh_ff[g][3] <= port_rx_frame[g].lba_mid;
            sh_ff[g][4] <= port_rx_frame[g].lba_hi;
            sh_ff[g][5] <= port_rx_frame[g].device;
            stat_ff[g]  <= port_rx_frame[g].status;
          end
          if (wr_en)
          begin
            if (is_plain(ix))
              sh_ff[g][ix[2:0]] <= wb;
            else if (ix == `DPSE_IX_STAT)
              cmd_ff[g] <= wb;
            else
              ctl_ff[g] <= wb;
          end
          if (busy_flag)
            stat_ff[g][`DPSE_BSY_BIT] <= 1'b1;
          if (ld_mrg)
          begin
            sh_ff[g][0] <= mrg_err;
            stat_ff[g]  <= mrg_stat;
          end
        end
      end

      // a second request while a frame is in flight is held, never dropped
      always_ff @(posedge core_clk or posedge rst)
      begin
        if (rst)
        begin
          ipend_ff[g] <= 1'b0;
          pend_ff[g]  <= 1'b0;
          txv_ff[g]   <= 1'b0;
          txf_ff[g]   <= '0;
        end
        else
        begin
          ipend_ff[g] <= (port_rx_valid[g] & port_rx_frame[g].irq) | (ipend_ff[g] & ~iclr);
          pend_ff[g]  <= send | (pend_ff[g] & ~load);
          if (load)
          begin
            txv_ff[g] <= 1'b1;
            txf_ff[g] <= img;
          end
          else if (port_tx_ready[g])
            txv_ff[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // host interrupt follows the primary port only
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      host_intrq_ff <= 1'b0;
    else
      host_intrq_ff <= ipend_ff[0] & ~sel & ~ctl_ff[0][`DPSE_INTERRUPT_DISABLE_BIT_BIT];
  end

  assign prdata        = prdata_ff;
  assign pready        = pready_ff;
  assign pslverr       = pslverr_ff;
  assign port_tx_valid = txv_ff;
  assign port_tx_frame = txf_ff;
  assign host_intrq    = host_intrq_ff;
  assign irq           = irq_ff;
endmodule

// [verif/dpse_dev_pair.sv]
// behavioural pair of serial devices facing the adapter ports
module dpse_dev_pair (
  // clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        rst,
  // behaviour controls
  input  wire logic                        slow,
  input  wire logic [1:0]                  mute,
  input  wire logic [1:0]                  bad,
  // adapter links
  input  wire logic [1:0]                  port_tx_valid,
  input  wire dpse_pkg::dpse_tx_type [1:0] port_tx_frame,
  output logic      [1:0]                  port_tx_ready,
  output logic      [1:0]                  port_rx_valid,
  output dpse_pkg::dpse_rx_type [1:0]      port_rx_frame
);
  timeunit 1ns;
  timeprecision 1ps;
  int dly [2];
  always @(posedge core_clk or posedge rst)
    for (int i = 0; i < 2; i++)
    begin
      if (rst)
      begin
        port_tx_ready[i] <= 1'b0;
        port_rx_valid[i] <= 1'b0;
        port_rx_frame[i] <= '0;
        dly[i] = 0;
      end
      else
      begin
        port_tx_ready[i] <= slow ? 1'($urandom % 4 == 0) : 1'b1;
        // every frame is ours whatever its device-select; soft-reset set gets no reply
        if (port_tx_valid[i] && port_tx_ready[i] && !port_tx_frame[i].control[2] && !mute[i])
          dly[i] = 9;
        else if (dly[i] > 0)
          dly[i] = dly[i] - 1;
        port_rx_valid[i] <= (dly[i] == 1);
        // idle lines toggle so a stale frame is never mistaken for a reply
        if (dly[i] == 1)
          port_rx_frame[i] <= '{error: bad[i] ? 8'h04 : 8'h01, status: 8'h50, irq: 1'b1,
                                default: 8'h00};
        else
          port_rx_frame[i] <= ~port_rx_frame[i];
      end
    end
endmodule

// [verif/dpse_props.sv]
// port-level assertions for the paired-port shadow emulation
module dpse_props (
  // clock and reset
  input wire logic                        core_clk,
  input wire logic                        rst,
  // apb slave
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [11:0]                 paddr,
  input wire logic [31:0]                 pwdata,
  input wire logic [31:0]                 prdata,
  input wire logic                        pready,
  input wire logic                        pslverr,
  // device links
  input wire logic [1:0]                  port_phy_ready,
  input wire logic [1:0]                  port_tx_valid,
  input wire dpse_pkg::dpse_tx_type [1:0] port_tx_frame,
  input wire logic [1:0]                  port_tx_ready
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_wait; $rose(penable) |-> !pready ##1 pready; endproperty
  a_wait: assert property (p_wait) else $error("apb wait state wrong");
  property p_win; pready |-> psel && penable; endproperty
  a_win: assert property (p_win) else $error("ready outside access");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("ready too long");
  property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("refused read not zero");
  property p_h0; port_tx_valid[0] && !port_tx_ready[0] |=> port_tx_valid[0]
    && $stable(port_tx_frame[0]); endproperty
  a_h0: assert property (p_h0) else $error("port0 frame dropped");
  property p_h1; port_tx_valid[1] && !port_tx_ready[1] |=> port_tx_valid[1]
    && $stable(port_tx_frame[1]); endproperty
  a_h1: assert property (p_h1) else $error("port1 frame dropped");
  property p_abs; port_tx_valid[1] |-> port_phy_ready[1]; endproperty
  a_abs: assert property (p_abs) else $error("frame to absent port");
  property p_diag; pready && pwrite && paddr == 12'h018 && pwdata[7:0] == 8'h90
    |-> ##[1:3] (port_tx_valid & port_phy_ready) != 2'b00; endproperty
  a_diag: assert property (p_diag) else $error("diagnostic not sent");
endmodule
bind dpse_top dpse_props u_props (.core_clk(core_clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .port_phy_ready(port_phy_ready),
  .port_tx_valid(port_tx_valid), .port_tx_frame(port_tx_frame), .port_tx_ready(port_tx_ready));

// [verif/dpse_top_bench.sv]
// self-checking bench for the paired-port shadow emulation
module dpse_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                        core_clk = 1'b0;
  logic                        rst = 1'b1;
  logic                        psel = 1'b0;
  logic                        penable = 1'b0;
  logic                        pwrite = 1'b0;
  logic                        slow = 1'b0;
  logic [11:0]                 paddr = 12'h000;
  logic [31:0]                 pwdata = 32'h0;
  logic [31:0]                 prdata;
  logic [31:0]                 rd;
  logic                        pready;
  logic                        pslverr;
  logic                        er;
  logic                        host_intrq;
  logic                        irq;
  logic [1:0]                  port_phy_ready = 2'b11;
  logic [1:0]                  mute = 2'b00;
  logic [1:0]                  bad = 2'b00;
  logic [1:0]                  tv;
  logic [1:0]                  tr;
  logic [1:0]                  rv;
  dpse_pkg::dpse_tx_type [1:0] tf;
  dpse_pkg::dpse_rx_type [1:0] rf;
  dpse_pkg::dpse_tx_type       lf [2];
  int                          n_mismatch = 0;
  int                          cmp_count = 0;
  int                          nf [2] = '{0, 0};
  int                          sh [2];
  dpse_top dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_phy_ready(port_phy_ready), .port_tx_valid(tv), .port_tx_frame(tf),
    .port_tx_ready(tr), .port_rx_valid(rv), .port_rx_frame(rf), .host_intrq(host_intrq), .irq(irq));
  dpse_dev_pair dev (.core_clk(core_clk), .rst(rst), .slow(slow), .mute(mute), .bad(bad),
    .port_tx_valid(tv), .port_tx_frame(tf), .port_tx_ready(tr), .port_rx_valid(rv),
    .port_rx_frame(rf));
  initial forever #20 core_clk = ~core_clk;
  always @(posedge core_clk)
    for (int i = 0; i < 2; i++)
    begin
      nf[i] += int'(tv[i] && tr[i]);
      if (tv[i] && tr[i])
        lf[i] = tf[i];
    end
  task automatic close_out;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // flags are registered up to two cycles behind their cause
  task automatic chkf(ref logic f, input logic e);
    repeat (2) @(negedge core_clk);
    chk({31'h0, f}, {31'h0, e});
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1 && n < 40)
    begin
      @(posedge core_clk);
      n++;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 40)
    begin
      n_mismatch++;
      close_out;
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic wbit(input int b);
    int k;
    k = 0;
    rd = '0;
    while (rd[b] !== 1'b1 && k < 60)
    begin
      xfer(1'b0, 12'h020, 32'h0);
      k++;
    end
    chk({31'h0, rd[b]}, 32'h1);
    if (rd[b] !== 1'b1)
      close_out;
  endtask
  // merged error: primary passes, secondary adds the fail bit unless absent or passing
  function automatic logic [31:0] mrg(input int p1, input int e1);
    return 32'(8'h01 | ((p1 != 0 && e1 != 1) ? 8'h80 : 8'h00));
  endfunction
  initial
  begin
    void'($urandom(44611));
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    rdc(12'h018, 32'h7f);
    rdc(12'h01c, 32'h7f);
    rdc(12'h004, 32'hff);
    xfer(1'b0, 12'h030, 32'h0);
    chk({31'h0, er}, 32'h1);
    for (int s = 0; s < 2; s++)
    begin
      sh[s] = $urandom % 256;
      wr(12'h014, 32'(s << 4));
      wr(12'h004, 32'(sh[s]));
    end
    rdc(12'h004, 32'(sh[1]));
    wr(12'h014, 32'h0);
    rdc(12'h004, 32'(sh[0]));
    slow <= 1'b1;
    wr(12'h024, 32'h1);
    wr(12'h018, 32'h20);
    xfer(1'b0, 12'h018, 32'h0);
    chk(rd & 32'h80, 32'h80);
    wbit(0);
    chkf(irq, 1'b1);
    chkf(host_intrq, 1'b1);
    wr(12'h014, 32'h10);
    chkf(host_intrq, 1'b0);
    wr(12'h014, 32'h0);
    chkf(host_intrq, 1'b1);
    wr(12'h01c, 32'h2);
    chkf(host_intrq, 1'b0);
    rdc(12'h018, 32'h50);
    wr(12'h020, 32'hf);
    chkf(irq, 1'b0);
    sh = nf;
    wr(12'h01c, 32'h4);
    wr(12'h01c, 32'h0);
    wbit(2);
    chk(32'(nf[0] - sh[0]), 32'h2);
    chk(32'(nf[1] - sh[1]), 32'h2);
    chk(32'(lf[1].control), 32'h0);
    rdc(12'h000, mrg(1, 1));
    // replies must beat the short timeout unless a port is muted
    slow <= 1'b0;
    wr(12'h02c, 32'h10);
    for (int v = 0; v < 3; v++)
    begin
      bad <= {v == 0, 1'b0};
      mute <= {v == 1, 1'b0};
      port_phy_ready <= {v != 2, 1'b1};
      wr(12'h020, 32'hf);
      sh = nf;
      wr(12'h018, 32'h90);
      wbit(2);
      chk(32'(lf[0].command), 32'h90);
      chk(32'(nf[1] - sh[1]), 32'(v != 2));
      rdc(12'h000, mrg(v != 2, v == 0 ? 4 : v == 1 ? -1 : 1));
    end
    wr(12'h014, 32'h10);
    rdc(12'h018, 32'h0);
    close_out;
  end
endmodule
